/* shared/ccsd_defs.svh */
// timing counts and field codes for the clock source select and divide block
// assumes a 200 MHz system clock; the fast and slow internal oscillators are modelled as tick rates
`ifndef CCSD_DEFS_SVH
`define CCSD_DEFS_SVH

`define CCSD_SYS_HZ 64'd200000000
`define CCSD_FAST_HZ 64'd24000000
`define CCSD_SLOW_HZ 64'd32000
// phase increments of the 32-bit accumulators, 2^32 * f / f_sys
`define CCSD_FAST_INC 32'((`CCSD_FAST_HZ << 32) / `CCSD_SYS_HZ)
`define CCSD_SLOW_INC 32'((`CCSD_SLOW_HZ << 32) / `CCSD_SYS_HZ)
// low-power slow oscillator drops the fine increment bits
`define CCSD_SLOW_LP_MASK 32'hFFFFF000
// fast ticks expected between two 1 ms frame markers, and tune window
`define CCSD_FRAME_TICKS 16'd24000
`define CCSD_TUNE_TOL 16'd60
`define CCSD_TRIM_STEP 16'h0040
// samples the fast-transient filter needs to accept a new level
`define CCSD_FILT_LEN 3
// divider codes
`define CCSD_DIV_ONE 7'h00
`define CCSD_DIV_TWO 7'h01
`define CCSD_CPU_MAX_CODE 3'h5
`define CCSD_CPU_MAX_N 3'h7

`endif

/* shared/ccsd_pkg.sv */
// types of the clock source select and divide block
// assumes ccsd_defs.svh for the numeric constants
`include "ccsd_defs.svh"
package ccsd_pkg;

   // source index into a divider's tick vector
   typedef enum logic [1:0] {
      CCSD_SRC_EXT = 2'h0,
      CCSD_SRC_FAST = 2'h1,
      CCSD_SRC_SLOW = 2'h2,
      CCSD_SRC_CAP = 2'h3
   } ccsd_src_t;

   typedef enum logic [1:0] {
      CCSD_AUX_EXT = 2'h0,
      CCSD_AUX_FAST = 2'h1,
      CCSD_AUX_SLOW = 2'h2,
      CCSD_AUX_CPU = 2'h3
   } ccsd_aux_t;

   // static configuration of the whole block
   typedef struct packed {
      logic xtal_en;
      logic filt_bypass;
      logic slow_lp;
      logic cpu_sel_ext;
      logic [2:0] cpu_speed;
      logic usb_sel_ext;
      logic usb_div2_dis;
      ccsd_src_t itmr_sel;
      logic [1:0] itmr_pre;
      ccsd_src_t cap_sel;
      ccsd_aux_t aux_sel;
   } ccsd_cfg_t;

   // derived clock enables
   typedef struct packed {
      logic cpu;
      logic usb;
      logic itmr;
      logic cap;
   } ccsd_ticks_t;

   typedef struct packed {
      logic [6:0] cnt;
      logic [6:0] ratio_m1;
      ccsd_src_t sel;
      logic tick;
   } ccsd_div_st_t;

   typedef struct packed {
      logic ext_s1;
      logic ext_s2;
      logic xtal_s1;
      logic xtal_s2;
      logic [`CCSD_FILT_LEN-1:0] hist;
      logic filt;
      logic ext_prev;
      logic ext_tick;
      logic [31:0] fast_ph;
      logic fast_tick;
      logic [31:0] slow_ph;
      logic slow_tick;
      logic [15:0] trim;
      logic [15:0] frame_cnt;
      logic frame_seen;
      logic aux;
   } ccsd_st_t;

endpackage : ccsd_pkg

/* rtl/ccsd_clk_div.sv */
// one derived clock enable: source multiplexer followed by a divider
// assumes all source ticks are one-cycle pulses on clk_i
`timescale 1ns/1ps
`include "ccsd_defs.svh"

module ccsd_clk_div (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic [3:0] src_i,
   input wire ccsd_pkg::ccsd_src_t sel_i,
   input wire logic [6:0] ratio_m1_i,
   output logic tick_o
);
   import ccsd_pkg::*;

   ccsd_div_st_t s_q;
   ccsd_div_st_t s_d;

   always_comb begin
      s_d = s_q;
      s_d.tick = 1'b0;
      if (src_i[s_q.sel]) begin
         if (s_q.cnt >= s_q.ratio_m1) begin
            s_d.cnt = 7'h00;
            s_d.tick = 1'b1;
            // new source and ratio only at a period end, no runt pulse
            s_d.sel = sel_i;
            s_d.ratio_m1 = ratio_m1_i;
         end else begin
            s_d.cnt = s_q.cnt + 7'h01;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         s_q <= '{cnt: 7'h00, ratio_m1: 7'h00, sel: CCSD_SRC_FAST,
                  tick: 1'b0};
      end else begin
         s_q <= s_d;
      end
   end

   assign tick_o = s_q.tick;

endmodule : ccsd_clk_div

/* rtl/ccsd_clk_ctrl.sv */
// clock source selection and distribution as one-cycle enables on clk_i
// assumes pins are asynchronous and frame markers come from clk_i logic
`timescale 1ns/1ps
`include "ccsd_defs.svh"

// Notes on behaviour
// - fast 24 MHz and slow 32 kHz internal oscillators are generated
// - with USB frames present and USB on the fast source, fast oscillator is tuned within 0.25 percent
// - slow oscillator ticks the wake-up logic while suspended
// - slow oscillator ticks sequential logic while the main clock stops
// - slow oscillator has low-power coarse mode and accurate normal mode
// - external source is crystal when enabled, otherwise the input pin
// - external path has a fast-transient filter that can be bypassed
// - CPU, USB, interval and capture clocks are separately selectable
// - CPU clock comes from external or fast internal oscillator
// - CPU source divides by 2^n, n from 0 to 5 or 7
// - USB clock from fast or external source with optional halving
// - interval clock picks ext, fast, slow or capture; prescale 1 to 4
// - capture clock picks external, fast or slow oscillator
// - auxiliary pin drives selected source unless the crystal uses it
// - fast source on USB always forces the divide-by-two on
// - USB halving applies while the divider disable control is clear
module ccsd_clk_ctrl (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire ccsd_pkg::ccsd_cfg_t cfg_i,
   input wire logic external_clock_input_i,
   input wire logic xtal_osc_i,
   input wire logic usb_frame_i,
   input wire logic suspend_i,
   input wire logic main_stop_i,
   output ccsd_pkg::ccsd_ticks_t ticks_o,
   output logic fast_tick_o,
   output logic slow_tick_o,
   output logic ext_tick_o,
   output logic wake_tick_o,
   output logic seq_tick_o,
   output logic auxiliary_clock_pin_o,
   output logic auxiliary_clock_pin_oe_o,
   output logic [15:0] fast_trim_o
);
   import ccsd_pkg::*;

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   // cpu divide ratio minus one from a speed code
   function automatic logic [6:0] cpu_ratio_m1(input logic [2:0] code);
      logic [2:0] n;
      n = (code > `CCSD_CPU_MAX_CODE) ? `CCSD_CPU_MAX_N : code;
      return 7'((8'h01 << n) - 8'h01);
   endfunction : cpu_ratio_m1

   // one step of a phase accumulator, carry out is the oscillator tick
   function automatic logic [32:0] phase_step(input logic [31:0] ph,
                                              input logic [31:0] inc);
      return {1'b0, ph} + {1'b0, inc};
   endfunction : phase_step

   // one trim step that holds at the ends rather than wrapping round
   function automatic logic [15:0] trim_next(input logic [15:0] t,
                                             input logic up);
      logic [16:0] r;
      if (up) begin
         r = {t[15], t} + {1'b0, `CCSD_TRIM_STEP};
      end else begin
         r = {t[15], t} - {1'b0, `CCSD_TRIM_STEP};
      end
      if (r[16] != r[15]) begin
         return r[16] ? 16'h8000 : 16'h7FFF;
      end
      return r[15:0];
   endfunction : trim_next

   // oscillator ticks in source index order, cap tick in the top slot
   function automatic logic [3:0] tick_vec(input logic cap,
                                           input ccsd_st_t s);
      return {cap, s.slow_tick, s.fast_tick, s.ext_tick};
   endfunction : tick_vec

   ccsd_st_t s_q;
   ccsd_st_t s_d;
   ccsd_ticks_t tk;
   logic ext_raw;
   logic ext_lvl;
   logic [32:0] fast_sum;
   logic [32:0] slow_sum;
   logic [31:0] fast_inc;
   logic [31:0] slow_inc;
   logic [6:0] usb_m1;

   // ------------------------------------------------------------
   // oscillators, external path, frame tuning
   // ------------------------------------------------------------
   always_comb begin
      s_d = s_q;
      s_d.ext_s1 = external_clock_input_i;
      s_d.ext_s2 = s_q.ext_s1;
      s_d.xtal_s1 = xtal_osc_i;
      s_d.xtal_s2 = s_q.xtal_s1;
      ext_raw = cfg_i.xtal_en ? s_q.xtal_s2 : s_q.ext_s2;
      s_d.hist = {s_q.hist[`CCSD_FILT_LEN-2:0], ext_raw};
      // level accepted only after the filter sees it steady
      if (&s_q.hist) begin
         s_d.filt = 1'b1;
      end else if (~|s_q.hist) begin
         s_d.filt = 1'b0;
      end
      ext_lvl = cfg_i.filt_bypass ? ext_raw : s_q.filt;
      s_d.ext_prev = ext_lvl;
      s_d.ext_tick = ext_lvl & ~s_q.ext_prev;

      fast_inc = `CCSD_FAST_INC + {{16{s_q.trim[15]}}, s_q.trim};
      fast_sum = phase_step(s_q.fast_ph, fast_inc);
      s_d.fast_ph = fast_sum[31:0];
      s_d.fast_tick = fast_sum[32];
      slow_inc = cfg_i.slow_lp ? (`CCSD_SLOW_INC & `CCSD_SLOW_LP_MASK)
                               : `CCSD_SLOW_INC;
      slow_sum = phase_step(s_q.slow_ph, slow_inc);
      s_d.slow_ph = slow_sum[31:0];
      s_d.slow_tick = slow_sum[32];

      // count fast ticks per frame and nudge the trim toward target
      if (s_q.fast_tick && s_q.frame_cnt != 16'hFFFF) begin
         s_d.frame_cnt = s_q.frame_cnt + 16'h0001;
      end
      if (usb_frame_i) begin
         s_d.frame_cnt = 16'h0000;
         s_d.frame_seen = 1'b1;
         if (s_q.frame_seen && !cfg_i.usb_sel_ext) begin
            if (s_q.frame_cnt > `CCSD_FRAME_TICKS + `CCSD_TUNE_TOL) begin
               s_d.trim = trim_next(s_q.trim, 1'b0);
            end else if (s_q.frame_cnt <
                         `CCSD_FRAME_TICKS - `CCSD_TUNE_TOL) begin
               s_d.trim = trim_next(s_q.trim, 1'b1);
            end
         end
      end
      if (suspend_i) begin
         s_d.frame_seen = 1'b0;
      end

      // auxiliary pin: toggled by ticks, or the filtered level itself
      case (cfg_i.aux_sel)
         CCSD_AUX_EXT: s_d.aux = ext_lvl;
         CCSD_AUX_FAST: s_d.aux = s_q.aux ^ s_q.fast_tick;
         CCSD_AUX_SLOW: s_d.aux = s_q.aux ^ s_q.slow_tick;
         CCSD_AUX_CPU: s_d.aux = s_q.aux ^ tk.cpu;
         default: s_d.aux = 1'b0;
      endcase
   end

   // ------------------------------------------------------------
   // state register
   // ------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   // ------------------------------------------------------------
   // derived clocks
   // ------------------------------------------------------------
   // fast source forces halving, else halve while disable is clear
   assign usb_m1 = (!cfg_i.usb_sel_ext || !cfg_i.usb_div2_dis) ?
                   `CCSD_DIV_TWO : `CCSD_DIV_ONE;

   ccsd_clk_div u_cpu (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .src_i(tick_vec(1'b0, s_q)),
      .sel_i(cfg_i.cpu_sel_ext ? CCSD_SRC_EXT : CCSD_SRC_FAST),
      .ratio_m1_i(cpu_ratio_m1(cfg_i.cpu_speed)),
      .tick_o(tk.cpu)
   );

   ccsd_clk_div u_usb (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .src_i(tick_vec(1'b0, s_q)),
      .sel_i(cfg_i.usb_sel_ext ? CCSD_SRC_EXT : CCSD_SRC_FAST),
      .ratio_m1_i(usb_m1),
      .tick_o(tk.usb)
   );

   ccsd_clk_div u_cap (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .src_i(tick_vec(1'b0, s_q)),
      .sel_i(cfg_i.cap_sel == CCSD_SRC_CAP ? CCSD_SRC_SLOW
                                             : cfg_i.cap_sel),
      .ratio_m1_i(`CCSD_DIV_ONE),
      .tick_o(tk.cap)
   );

   ccsd_clk_div u_itmr (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .src_i(tick_vec(tk.cap, s_q)),
      .sel_i(cfg_i.itmr_sel),
      .ratio_m1_i({5'h00, cfg_i.itmr_pre}),
      .tick_o(tk.itmr)
   );

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   assign ticks_o = tk;
   assign fast_tick_o = s_q.fast_tick;
   assign slow_tick_o = s_q.slow_tick;
   assign ext_tick_o = s_q.ext_tick;
   assign wake_tick_o = suspend_i & s_q.slow_tick;
   assign seq_tick_o = main_stop_i ? s_q.slow_tick : tk.cpu;
   assign auxiliary_clock_pin_o = s_q.aux;
   assign auxiliary_clock_pin_oe_o = ~cfg_i.xtal_en;
   assign fast_trim_o = s_q.trim;

endmodule : ccsd_clk_ctrl

/* sim/ccsd_clk_ctrl_monitor.sv */
// assertions on the ports of ccsd_clk_ctrl
// assumes one clock domain; bound at the foot of this file
`timescale 1ns/1ps
module ccsd_clk_ctrl_monitor (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire ccsd_pkg::ccsd_cfg_t cfg_i,
   input wire logic external_clock_input_i,
   input wire logic xtal_osc_i,
   input wire logic suspend_i,
   input wire logic main_stop_i,
   input wire ccsd_pkg::ccsd_ticks_t ticks_o,
   input wire logic fast_tick_o,
   input wire logic slow_tick_o,
   input wire logic ext_tick_o,
   input wire logic wake_tick_o,
   input wire logic seq_tick_o
);
   import ccsd_pkg::*;
   // ---
   // config age and cpu tick spacing
   // ---
   ccsd_cfg_t cfg_q;
   logic [11:0] age_q;
   logic [10:0] gap_q;
   logic ok;
   int n;
   // ok: config unchanged long enough for the cpu and usb dividers to settle
   assign ok = age_q > 12'hA80;
   assign n = cfg_i.cpu_speed > 3'h5 ? 7 : int'(cfg_i.cpu_speed);
   always_ff @(posedge clk_i) begin
      cfg_q <= cfg_i;
      if (!rst_n_i || cfg_i != cfg_q) age_q <= 12'h000;
      else if (!ok) age_q <= age_q + 12'h001;
      if (!rst_n_i || ticks_o.cpu) gap_q <= 11'h001;
      else if (gap_q != 11'h7FF) gap_q <= gap_q + 11'h001;
   end
   // ---
   // properties
   // ---
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   a_fast_tick_gap: assert property (fast_tick_o |=>
      !fast_tick_o [*7] ##[1:2] fast_tick_o) else $error("fast gap");
   a_wake_slow_tick: assert property (
      wake_tick_o == (suspend_i && slow_tick_o)) else $error("wake");
   a_seq_tick_src: assert property (
      seq_tick_o == (main_stop_i ? slow_tick_o : ticks_o.cpu))
      else $error("seq tick");
   a_ext_src_edge: assert property (ok && $rose(cfg_i.xtal_en ?
      xtal_osc_i : external_clock_input_i) |-> ##[1:9] ext_tick_o)
      else $error("ext edge");
   a_cpu_div_gap: assert property (ok && ticks_o.cpu &&
      !cfg_i.cpu_sel_ext |-> gap_q inside {[8 << n : 9 << n]})
      else $error("cpu gap");
   a_usb_src_tick: assert property (ok && ticks_o.usb |->
      ($past(cfg_i.usb_sel_ext) ? $past(ext_tick_o) : $past(fast_tick_o)))
      else $error("usb source");
   a_usb_fast_half: assert property (ok && ticks_o.usb &&
      !cfg_i.usb_sel_ext |=> !ticks_o.usb [*8] ##1 !ticks_o.usb [*7]
      ##[1:2] ticks_o.usb)
      else $error("usb halving");
   a_usb_undivided: assert property (ok && cfg_i.usb_sel_ext &&
      cfg_i.usb_div2_dis && $past(ext_tick_o) |-> ticks_o.usb)
      else $error("usb pass");
endmodule : ccsd_clk_ctrl_monitor

bind ccsd_clk_ctrl ccsd_clk_ctrl_monitor u_mon (.clk_i, .rst_n_i, .cfg_i,
   .external_clock_input_i, .xtal_osc_i, .suspend_i, .main_stop_i,
   .ticks_o, .fast_tick_o, .slow_tick_o, .ext_tick_o, .wake_tick_o,
   .seq_tick_o);

/* sim/testbench.sv */
// self-checking bench for ccsd_clk_ctrl
// assumes pin and crystal clocks of 20 and 26 cycles made here
`timescale 1ns/1ps
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin \
   fail_count++; $display("[ERR] %s exp %0h got %0h", nm, e, g); end end
module testbench;
   import ccsd_pkg::*;
   typedef struct packed {
      logic [1:0] k;
      logic [2:0] c;
      logic [11:0] p;
   } ccsd_row_t;
   // kind, code, expected period in cycles of the measured tick
   ccsd_row_t rows [19] = '{{2'h0, 3'h0, 12'h014}, {2'h0, 3'h1, 12'h028},
      {2'h0, 3'h2, 12'h050}, {2'h0, 3'h3, 12'h0A0}, {2'h0, 3'h4, 12'h140},
      {2'h0, 3'h5, 12'h280}, {2'h0, 3'h6, 12'hA00}, {2'h0, 3'h7, 12'hA00},
      {2'h1, 3'h0, 12'h028}, {2'h1, 3'h1, 12'h014}, {2'h2, 3'h0, 12'h014},
      {2'h2, 3'h1, 12'h028}, {2'h2, 3'h2, 12'h03C}, {2'h2, 3'h3, 12'h050},
      {2'h2, 3'h5, 12'h028}, {2'h3, 3'h0, 12'h014}, {2'h3, 3'h1, 12'h01A},
      {2'h3, 3'h2, 12'h014}, {2'h3, 3'h3, 12'h01A}};
   logic clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   ccsd_cfg_t base, c, cfg_i;
   logic external_clock_input_i = 1'b0;
   logic xtal_osc_i = 1'b0;
   logic usb_frame_i = 1'b0;
   logic suspend_i = 1'b0;
   logic main_stop_i = 1'b0;
   ccsd_ticks_t ticks_o;
   logic fast_tick_o, slow_tick_o, ext_tick_o, wake_tick_o, seq_tick_o;
   logic auxiliary_clock_pin_o, auxiliary_clock_pin_oe_o, a1;
   logic [15:0] fast_trim_o;
   logic [4:0] tv;
   int fail_count = 0;
   int samples_checked = 0;
   int ec = 0;
   int xc = 0;
   int n, s;
   assign tv = {slow_tick_o, ticks_o};
   ccsd_clk_ctrl dut (.clk_i, .rst_n_i, .cfg_i, .external_clock_input_i,
      .xtal_osc_i, .usb_frame_i, .suspend_i, .main_stop_i, .ticks_o,
      .fast_tick_o, .slow_tick_o, .ext_tick_o, .wake_tick_o, .seq_tick_o,
      .auxiliary_clock_pin_o, .auxiliary_clock_pin_oe_o, .fast_trim_o);
   always #2.5 clk_i = ~clk_i;
   always @(negedge clk_i) begin
      ec = ec == 9 ? 0 : ec + 1;
      xc = xc == 12 ? 0 : xc + 1;
      if (ec == 0) external_clock_input_i <= ~external_clock_input_i;
      if (xc == 0) xtal_osc_i <= ~xtal_osc_i;
   end
   // waits for tick b (4 = slow), returns cycles waited
   task automatic wt(input int b, output int m);
      m = 0;
      do begin
         @(negedge clk_i);
         m++;
      end while (tv[b] !== 1'b1 && m < 8000);
      if (m >= 8000) fail_count++;
   endtask : wt
   task automatic frame();
      repeat (1000) @(negedge clk_i);
      usb_frame_i = 1'b1;
      @(negedge clk_i);
      usb_frame_i = 1'b0;
   endtask : frame
   task automatic test_done();
      $display("checked %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : test_done
   initial begin
      #450000;
      fail_count++;
      test_done();
   end
   initial begin
      base = '0;
      base.cpu_sel_ext = 1'b1;
      base.usb_sel_ext = 1'b1;
      base.aux_sel = CCSD_AUX_CPU;
      cfg_i = base;
      repeat (16) @(negedge clk_i);
      `CHK("reset ticks", 4'h0, ticks_o)
      `CHK("reset trim", 16'h0000, fast_trim_o)
      `CHK("reset aux", 1'b0, auxiliary_clock_pin_o)
      rst_n_i = 1'b1;
      $display("reset test done");
      foreach (rows[i]) begin
         c = base;
         case (rows[i].k)
            2'h0: c.cpu_speed = rows[i].c;
            2'h1: c.usb_div2_dis = rows[i].c[0];
            2'h2: begin
               c.itmr_pre = rows[i].c[1:0];
               if (rows[i].c[2]) c.itmr_sel = CCSD_SRC_CAP;
            end
            default: begin
               c.xtal_en = rows[i].c[0];
               c.filt_bypass = rows[i].c[1];
            end
         endcase
         s = rows[i].k == 2'h1 ? 2 : rows[i].k == 2'h2 ? 1 : 3;
         cfg_i = c;
         repeat (3) wt(s, n);
         `CHK("period", rows[i].p, 12'(n))
         $display("row %0d done", i);
      end
      `CHK("aux enable", 1'b0, auxiliary_clock_pin_oe_o)
      cfg_i = base;
      repeat (3) wt(3, n);
      `CHK("aux enable", 1'b1, auxiliary_clock_pin_oe_o)
      repeat (2) @(negedge clk_i);
      a1 = auxiliary_clock_pin_o;
      wt(3, n);
      repeat (2) @(negedge clk_i);
      `CHK("aux toggle", 1'b1, auxiliary_clock_pin_o ^ a1)
      $display("aux test done");
      c = base;
      c.cpu_speed = 3'h5;
      cfg_i = c;
      repeat (2) wt(3, n);
      c.cpu_speed = 3'h0;
      cfg_i = c;
      wt(3, n);
      `CHK("old period kept", 12'h280, 12'(n))
      wt(3, n);
      `CHK("new period", 12'h014, 12'(n))
      $display("switch test done");
      c = base;
      c.cpu_sel_ext = 1'b0;
      c.cpu_speed = 3'h2;
      c.usb_sel_ext = 1'b0;
      c.usb_div2_dis = 1'b1;
      cfg_i = c;
      repeat (3) frame();
      @(negedge clk_i);
      `CHK("trim raised", 16'h0080, fast_trim_o)
      c.usb_sel_ext = 1'b1;
      cfg_i = c;
      repeat (3) frame();
      `CHK("trim held", 16'h0080, fast_trim_o)
      $display("trim test done");
      suspend_i = 1'b1;
      main_stop_i = 1'b1;
      wt(4, n);
      `CHK("wake tick", 1'b1, wake_tick_o)
      `CHK("seq tick", 1'b1, seq_tick_o)
      wt(4, n);
      `CHK("slow period", 10'h271, 10'(n / 10))
      c.slow_lp = 1'b1;
      cfg_i = c;
      wt(4, n);
      wt(4, n);
      `CHK("slow lp period", 10'h273, 10'(n / 10))
      $display("slow test done");
      rst_n_i = 1'b0;
      cfg_i = base;
      repeat (2) @(negedge clk_i);
      `CHK("rerun ticks", 4'h0, ticks_o)
      `CHK("rerun trim", 16'h0000, fast_trim_o)
      `CHK("rerun aux", 1'b0, auxiliary_clock_pin_o)
      rst_n_i = 1'b1;
      repeat (3) wt(3, n);
      `CHK("period after reset", 12'h014, 12'(n))
      $display("reset rerun test done");
      test_done();
   end
endmodule : testbench
